/* include/qdr_pkg.sv */
// Constants, types and decode helpers for the quad/dual read command logic.
// Assumes SCK, CS# and I/O inputs are already synchronous to mclk.
package qdr_pkg;

  // Instruction codes
  localparam logic [7:0] QUAD_OUTPUT_READ_CMD = 8'h6b;
  localparam logic [7:0] QUAD_OUTPUT_READ_4BYTE_CMD = 8'h6c;
  localparam logic [7:0] DUAL_IO_READ_CMD = 8'hbb;
  localparam logic [7:0] DUAL_IO_READ_4BYTE_CMD = 8'hbc;

  // Mode byte upper nibble that keeps continuous mode
  localparam logic [3:0] MODE_CONT_NIBBLE = 4'ha;

  // Configuration register one layout
  localparam int CR_QUAD_BIT = 1;
  localparam int CR_LAT_LSB = 6;
  localparam int CR_LAT_MSB = 7;

  // Frame geometry
  localparam int ADDR_W = 32;
  localparam logic [5:0] CMD_LAST = 6'h07;
  localparam logic [5:0] MODE_LAST = 6'h03;
  localparam logic [5:0] ADDR3_BITS = 6'h18;
  localparam logic [5:0] ADDR4_BITS = 6'h20;
  localparam logic [1:0] QUAD_LAST_CHUNK = 2'h1;
  localparam logic [1:0] DUAL_LAST_CHUNK = 2'h3;
  localparam logic [3:0] QUAD_OE = 4'hf;
  localparam logic [3:0] DUAL_OE = 4'h3;
  localparam logic [7:0] ADDR3_MASK_HI = 8'h00;

  // Dummy cycles per latency code
  localparam logic [5:0] DUMMY_CODE0 = 6'h08;
  localparam logic [5:0] DUMMY_CODE1 = 6'h04;
  localparam logic [5:0] DUMMY_CODE2 = 6'h05;
  localparam logic [5:0] DUMMY_CODE3 = 6'h00;

  typedef enum logic [2:0] {
    ST_IDLE, ST_CMD, ST_ADDR, ST_MODE, ST_DUMMY, ST_DATA, ST_IGNORE
  } qdr_state_t;

  function automatic logic [5:0] qdr_dummy_cycles(input logic [1:0] code);
    case (code)
      2'h0: qdr_dummy_cycles = DUMMY_CODE0;
      2'h1: qdr_dummy_cycles = DUMMY_CODE1;
      2'h2: qdr_dummy_cycles = DUMMY_CODE2;
      default: qdr_dummy_cycles = DUMMY_CODE3;
    endcase
  endfunction : qdr_dummy_cycles

  // Pick the bits driven on a falling edge from the current byte
  function automatic logic [3:0] qdr_chunk(input logic [7:0] b, input logic [1:0] idx, input logic quad);
    if (quad) begin
      qdr_chunk = idx[0] ? b[3:0] : b[7:4];
    end else begin
      case (idx)
        2'h0: qdr_chunk = {2'h0, b[7:6]};
        2'h1: qdr_chunk = {2'h0, b[5:4]};
        2'h2: qdr_chunk = {2'h0, b[3:2]};
        default: qdr_chunk = {2'h0, b[1:0]};
      endcase
    end
  endfunction : qdr_chunk

endpackage : qdr_pkg

/* rtl/qdr_sck_edge.sv */
// Edge detection of SCK and CS# in the mclk domain.
// Assumes both inputs are synchronous to mclk and SCK is slower than mclk / 2.
`timescale 1ns/10ps
module qdr_sck_edge (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic sck,
  input wire logic cs_n,
  output logic sck_rise,
  output logic sck_fall,
  output logic cs_rise,
  output logic cs_fall
);

  logic sck_reg;
  logic cs_n_reg;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sck_reg <= 1'b0;
      cs_n_reg <= 1'b1;
    end else begin
      sck_reg <= sck;
      cs_n_reg <= cs_n;
    end
  end

  assign sck_rise = sck & ~sck_reg & ~cs_n;
  assign sck_fall = ~sck & sck_reg & ~cs_n;
  assign cs_rise = cs_n & ~cs_n_reg;
  assign cs_fall = ~cs_n & cs_n_reg;

endmodule : qdr_sck_edge

/* rtl/qdr_read_ctrl.sv */
// Serial flash command logic for Quad Output Read and Dual I/O Read.
// Assumes mem_rd_data follows mem_addr within the same mclk cycle.
// Operation
// - Quad output read: 3/4-byte address by mode
// - Quad data: one nibble per falling edge
// - Quad dummy cycles ignore I/O lines
// - Address increments per byte, wraps to zero
// - Quad reads need configuration quad bit set
// - Dual I/O read: 3/4-byte address by mode
// - Dual address two bits per rising edge
// - Standard table: instruction, address, latency only
// - Enhanced table: instruction, address, mode, latency
// - Mode nibble A keeps continuous, skips instruction
// - Other nibble leaves continuous at CS rise
// - Short invalid frame leaves continuous mode
// - Mode cycles add to initial latency, not counted in it
// - Dual data: two bits per falling edge
// - Dummy count from latency code field
// - Instruction byte one bit per rising edge
// - External-address bit selects 4-byte addressing
// - Dummy counted falling to falling edge
`timescale 1ns/10ps
module qdr_read_ctrl (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic [3:0] io_in,
  output logic [3:0] io_out,
  output logic [3:0] io_oe,
  input wire logic [7:0] config_register_one,
  input wire logic four_byte_addr_enable,
  input wire logic enhanced_latency_table,
  output logic [31:0] mem_addr,
  output logic mem_rd_en,
  input wire logic [7:0] mem_rd_data,
  output logic cont_mode
);

  logic sck_rise;
  logic sck_fall;
  logic cs_rise;
  logic cs_fall;

  qdr_sck_edge u_edge (
    .mclk(mclk),
    .rstn(rstn),
    .sck(sck),
    .cs_n(cs_n),
    .sck_rise(sck_rise),
    .sck_fall(sck_fall),
    .cs_rise(cs_rise),
    .cs_fall(cs_fall)
  );

  qdr_pkg::qdr_state_t state_reg, state_next;
  logic [5:0] cnt_reg, cnt_next;
  logic [5:0] addr_last_reg, addr_last_next;
  logic [31:0] shift_reg, shift_next;
  logic [31:0] addr_reg, addr_next;
  logic [7:0] mode_reg, mode_next;
  logic [1:0] chunk_reg, chunk_next;
  logic [3:0] io_out_reg, io_out_next;
  logic [3:0] io_oe_reg, io_oe_next;
  logic quad_reg, quad_next;
  logic mode_en_reg, mode_en_next;
  logic mode_done_reg, mode_done_next;
  logic addr4_reg, addr4_next;
  logic cont_reg, cont_next;

  // Decoding of the incoming instruction and configuration
  wire [7:0] op_byte = {shift_reg[6:0], io_in[0]};
  wire is_quad_rd = (op_byte == qdr_pkg::QUAD_OUTPUT_READ_CMD);
  wire is_quad_rd4 = (op_byte == qdr_pkg::QUAD_OUTPUT_READ_4BYTE_CMD);
  wire is_dual_rd = (op_byte == qdr_pkg::DUAL_IO_READ_CMD);
  wire is_dual_rd4 = (op_byte == qdr_pkg::DUAL_IO_READ_4BYTE_CMD);
  wire quad_enable = config_register_one[qdr_pkg::CR_QUAD_BIT];
  wire [1:0] latency_code = config_register_one[qdr_pkg::CR_LAT_MSB:qdr_pkg::CR_LAT_LSB];
  wire [5:0] dummy_total = qdr_pkg::qdr_dummy_cycles(latency_code);
  wire op_addr4 = is_quad_rd4 | is_dual_rd4 | four_byte_addr_enable;
  wire [5:0] op_bits = op_addr4 ? qdr_pkg::ADDR4_BITS : qdr_pkg::ADDR3_BITS;
  wire [5:0] dual_last = {1'b0, op_bits[5:1]} - 6'h01;
  wire [5:0] quad_last = op_bits - 6'h01;
  wire [5:0] cont_last = cont_addr_last(addr4_reg);

  // Address shifting, one bit for quad output, two for dual I/O
  wire [31:0] addr_shift = quad_reg ? {shift_reg[30:0], io_in[0]} : {shift_reg[29:0], io_in[1:0]};
  wire [31:0] addr_full = addr4_reg ? addr_shift : {qdr_pkg::ADDR3_MASK_HI, addr_shift[23:0]};
  wire [1:0] last_chunk = quad_reg ? qdr_pkg::QUAD_LAST_CHUNK : qdr_pkg::DUAL_LAST_CHUNK;
  wire [3:0] drive_val = qdr_pkg::qdr_chunk(mem_rd_data, chunk_reg, quad_reg);
  wire [3:0] oe_mask = quad_reg ? qdr_pkg::QUAD_OE : qdr_pkg::DUAL_OE;

  function automatic logic [5:0] cont_addr_last(input logic a4);
    cont_addr_last = a4 ? ({1'b0, qdr_pkg::ADDR4_BITS[5:1]} - 6'h01) : ({1'b0, qdr_pkg::ADDR3_BITS[5:1]} - 6'h01);
  endfunction : cont_addr_last

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    addr_last_next = addr_last_reg;
    shift_next = shift_reg;
    addr_next = addr_reg;
    mode_next = mode_reg;
    chunk_next = chunk_reg;
    io_out_next = io_out_reg;
    io_oe_next = io_oe_reg;
    quad_next = quad_reg;
    mode_en_next = mode_en_reg;
    mode_done_next = mode_done_reg;
    addr4_next = addr4_reg;
    cont_next = cont_reg;
    if (cs_rise) begin
      state_next = qdr_pkg::ST_IDLE;
      io_oe_next = 4'h0;
      // Continuous mode survives only a completed mode byte with nibble A
      cont_next = mode_done_reg && (mode_reg[7:4] == qdr_pkg::MODE_CONT_NIBBLE);
      mode_done_next = 1'b0;
    end else if (cs_fall) begin
      cnt_next = 6'h00;
      chunk_next = 2'h0;
      shift_next = 32'h0;
      if (cont_reg) begin
        // No instruction: address follows directly
        state_next = qdr_pkg::ST_ADDR;
        quad_next = 1'b0;
        mode_en_next = 1'b1;
        addr_last_next = cont_last;
      end else begin
        state_next = qdr_pkg::ST_CMD;
      end
    end else begin
      case (state_reg)
        qdr_pkg::ST_CMD: begin
          if (sck_rise) begin
            shift_next = {shift_reg[30:0], io_in[0]};
            cnt_next = cnt_reg + 6'h01;
            if (cnt_reg == qdr_pkg::CMD_LAST) begin
              cnt_next = 6'h00;
              shift_next = 32'h0;
              addr4_next = op_addr4;
              if ((is_quad_rd || is_quad_rd4) && quad_enable) begin
                state_next = qdr_pkg::ST_ADDR;
                quad_next = 1'b1;
                mode_en_next = 1'b0;
                addr_last_next = quad_last;
              end else if (is_dual_rd || is_dual_rd4) begin
                state_next = qdr_pkg::ST_ADDR;
                quad_next = 1'b0;
                mode_en_next = enhanced_latency_table;
                addr_last_next = dual_last;
              end else begin
                state_next = qdr_pkg::ST_IGNORE;
              end
            end
          end
        end
        qdr_pkg::ST_ADDR: begin
          if (sck_rise) begin
            shift_next = addr_shift;
            cnt_next = cnt_reg + 6'h01;
            if (cnt_reg == addr_last_reg) begin
              cnt_next = 6'h00;
              addr_next = addr_full;
              state_next = mode_en_reg ? qdr_pkg::ST_MODE : qdr_pkg::ST_DUMMY;
            end
          end
        end
        qdr_pkg::ST_MODE: begin
          if (sck_rise) begin
            mode_next = {mode_reg[5:0], io_in[1:0]};
            cnt_next = cnt_reg + 6'h01;
            if (cnt_reg == qdr_pkg::MODE_LAST) begin
              cnt_next = 6'h00;
              mode_done_next = 1'b1;
              state_next = qdr_pkg::ST_DUMMY;
            end
          end
        end
        qdr_pkg::ST_DUMMY: begin
          // I/O inputs are not looked at here
          if (sck_fall) begin
            if (cnt_reg == dummy_total) begin
              state_next = qdr_pkg::ST_DATA;
              io_oe_next = oe_mask;
              io_out_next = drive_val;
              chunk_next = chunk_reg + 2'h1;
            end else begin
              cnt_next = cnt_reg + 6'h01;
            end
          end
        end
        qdr_pkg::ST_DATA: begin
          if (sck_fall) begin
            io_out_next = drive_val;
            chunk_next = chunk_reg + 2'h1;
          end
        end
        default: begin
          state_next = state_reg;
        end
      endcase
      // Byte finished: step the address, wrapping past the top
      if ((state_next == qdr_pkg::ST_DATA) && sck_fall && (chunk_reg == last_chunk)) begin
        addr_next = addr_reg + 32'h1;
        chunk_next = 2'h0;
      end
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= qdr_pkg::ST_IDLE;
      cnt_reg <= 6'h00;
      addr_last_reg <= 6'h00;
      shift_reg <= 32'h0;
      addr_reg <= 32'h0;
      mode_reg <= 8'h00;
      chunk_reg <= 2'h0;
      io_out_reg <= 4'h0;
      io_oe_reg <= 4'h0;
      quad_reg <= 1'b0;
      mode_en_reg <= 1'b0;
      mode_done_reg <= 1'b0;
      addr4_reg <= 1'b0;
      cont_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      addr_last_reg <= addr_last_next;
      shift_reg <= shift_next;
      addr_reg <= addr_next;
      mode_reg <= mode_next;
      chunk_reg <= chunk_next;
      io_out_reg <= io_out_next;
      io_oe_reg <= io_oe_next;
      quad_reg <= quad_next;
      mode_en_reg <= mode_en_next;
      mode_done_reg <= mode_done_next;
      addr4_reg <= addr4_next;
      cont_reg <= cont_next;
    end
  end

  assign io_out = io_out_reg;
  assign io_oe = io_oe_reg;
  assign mem_addr = addr_reg;
  assign mem_rd_en = (state_reg == qdr_pkg::ST_DUMMY) || (state_reg == qdr_pkg::ST_DATA);
  assign cont_mode = cont_reg;

endmodule : qdr_read_ctrl

/* verif/qdr_read_ctrl_sva.sv */
// Port-level checks on the quad/dual read command logic.
// Assumes binding to qdr_read_ctrl with SCK phases of three mclk cycles.
`timescale 1ns/10ps
module qdr_read_ctrl_sva (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic [3:0] io_in,
  input wire logic [3:0] io_out,
  input wire logic [3:0] io_oe,
  input wire logic [7:0] config_register_one,
  input wire logic four_byte_addr_enable,
  input wire logic enhanced_latency_table,
  input wire logic [31:0] mem_addr,
  input wire logic mem_rd_en,
  input wire logic [7:0] mem_rd_data,
  input wire logic cont_mode
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);
  sequence s_sck_held;
    sck ##1 sck;
  endsequence
  sequence s_sel_held;
    (!cs_n)[*4];
  endsequence
  property p_out_on_fall;
    s_sck_held |-> $stable(io_out);
  endproperty
  a_out_on_fall: assert property (p_out_on_fall) else $error("data changed in high phase");
  property p_oe_codes;
    (io_oe == 4'h0) || (io_oe == 4'h3) || (io_oe == 4'hf);
  endproperty
  a_oe_codes: assert property (p_oe_codes) else $error("illegal enable set");
  property p_quad_qe;
    (io_oe == 4'hf) |-> config_register_one[1];
  endproperty
  a_quad_qe: assert property (p_quad_qe) else $error("quad drive without enable bit");
  property p_quiet_on_select;
    $fell(cs_n) |-> ##1 (io_oe == 4'h0)[*8];
  endproperty
  a_quiet_on_select: assert property (p_quiet_on_select) else $error("drive during address");
  property p_release;
    $rose(cs_n) |-> ##[1:4] (io_oe == 4'h0);
  endproperty
  a_release: assert property (p_release) else $error("drive after deselect");
  property p_addr_step;
    mem_rd_en && $past(mem_rd_en) && $changed(mem_addr) |-> mem_addr == $past(mem_addr) + 32'h1;
  endproperty
  a_addr_step: assert property (p_addr_step) else $error("address step not one");
  property p_cont_hold;
    s_sel_held |-> $stable(cont_mode);
  endproperty
  a_cont_hold: assert property (p_cont_hold) else $error("mode flag moved while selected");
  property p_cont_enh;
    $rose(cont_mode) |-> enhanced_latency_table;
  endproperty
  a_cont_enh: assert property (p_cont_enh) else $error("continuous mode without mode cycles");
  property p_drive_in_data;
    (io_oe != 4'h0) |-> mem_rd_en;
  endproperty
  a_drive_in_data: assert property (p_drive_in_data) else $error("data driven outside read phase");
endmodule : qdr_read_ctrl_sva

/* verif/qdr_host_model.sv */
// Host memory controller model: drives one read frame per call.
// Assumes calls start just after an mclk rising edge.
`timescale 1ns/10ps
module qdr_host_model (
  input wire logic mclk,
  output logic sck,
  output logic cs_n,
  output logic [3:0] io_in,
  input wire logic [3:0] io_out,
  input wire logic [3:0] io_oe
);
  logic [3:0] drv = 4'h0;
  logic hold = 1'h1;
  logic [3:0] oe_seen = 4'h0;
  logic [7:0] got [0:2];
  // Released lines show the inverse of the last value
  assign io_in = (io_oe & io_out) | (~io_oe & (hold ? drv : ~drv));
  initial begin
    sck = 1'h0;
    cs_n = 1'h1;
  end
  task automatic half(input logic lvl);
    sck = lvl;
    repeat (3) @(posedge mclk);
    #1;
  endtask : half
  task automatic cyc(input logic [3:0] v, input logic rel);
    drv = v;
    half(1'h1);
    hold = hold && !rel;
    half(1'h0);
  endtask : cyc
  task automatic burst(input int n);
    cs_n = 1'h0;
    half(1'h0);
    repeat (n) cyc(4'h0, 1'h0);
    cs_n = 1'h1;
    hold = 1'h1;
    repeat (6) @(posedge mclk);
    #1;
  endtask : burst
  task automatic frame(input logic [7:0] cmd, input logic wc, input logic [31:0] addr, input int abits,
      input logic dual, input logic wm, input logic [7:0] mode, input int ndum);
    int k;
    logic [7:0] b;
    oe_seen = 4'h0;
    cs_n = 1'h0;
    half(1'h0);
    for (k = 7; k >= 0 && wc; k--) cyc({3'h0, cmd[k]}, 1'h0);
    for (k = abits - 1; k >= 0; k = k - (dual ? 2 : 1)) begin
      cyc(dual ? {2'h0, addr[k -: 2]} : {3'h0, addr[k]}, k == (dual ? 1 : 0) && !wm);
    end
    for (k = 7; k > 0 && wm; k -= 2) cyc({2'h0, mode[k -: 2]}, k == 1);
    repeat (ndum) begin
      half(1'h1);
      half(1'h0);
    end
    for (k = 0; k < 12; k++) begin
      half(1'h1);
      oe_seen = oe_seen | io_oe;
      b = dual ? {b[5:0], io_in[1:0]} : {b[3:0], io_in};
      if (k % (dual ? 4 : 2) == (dual ? 3 : 1)) got[k / (dual ? 4 : 2)] = b;
      half(1'h0);
      if (!dual && k == 5) break;
    end
    burst(0);
  endtask : frame
endmodule : qdr_host_model

/* verif/tb_quad_dual_io_read_cmds.sv */
// Self-checking bench for the quad/dual read command logic.
// Assumes qdr_host_model plays the memory controller on the link.
`timescale 1ns/10ps
module tb_quad_dual_io_read_cmds;
  typedef struct packed {logic [7:0] cmd; logic wc; logic ext; logic enh; logic [1:0] lat; logic [31:0] addr;
    logic [7:0] mode; logic [3:0] oe; logic cm;} qdr_row_t;
  logic mclk, rstn, sck, cs_n, four_byte_addr_enable, enhanced_latency_table, mem_rd_en, cont_mode;
  logic [3:0] io_in, io_out, io_oe;
  logic [7:0] config_register_one, mem_rd_data;
  logic [31:0] mem_addr;
  int bad_count = 0;
  int checked = 0;
  int dum_tab [0:3] = '{8, 4, 5, 0};
  qdr_row_t rows [0:8] = '{
    '{8'h6b, 1'h1, 1'h0, 1'h0, 2'h3, 32'h00123456, 8'h00, 4'hf, 1'h0},
    '{8'h6c, 1'h1, 1'h0, 1'h0, 2'h1, 32'hfffffffe, 8'h00, 4'hf, 1'h0},
    '{8'h6b, 1'h1, 1'h1, 1'h0, 2'h2, 32'h12345678, 8'h00, 4'hf, 1'h0},
    '{8'hbb, 1'h1, 1'h0, 1'h0, 2'h0, 32'h00abcdef, 8'h00, 4'h3, 1'h0},
    '{8'hbc, 1'h1, 1'h0, 1'h0, 2'h3, 32'h89abcdef, 8'h00, 4'h3, 1'h0},
    '{8'hbb, 1'h1, 1'h1, 1'h1, 2'h1, 32'h7ffffffe, 8'ha5, 4'h3, 1'h1},
    '{8'hbb, 1'h0, 1'h1, 1'h1, 2'h2, 32'h00000010, 8'h3c, 4'h3, 1'h0},
    '{8'hbb, 1'h1, 1'h0, 1'h1, 2'h0, 32'h00fedcb0, 8'ha0, 4'h3, 1'h1},
    '{8'hbb, 1'h0, 1'h0, 1'h1, 2'h3, 32'h00000123, 8'h50, 4'h3, 1'h0}};
  assign mem_rd_data = mem_addr[7:0] + mem_addr[31:24] + 8'h11;
  qdr_read_ctrl uut (.mclk(mclk), .rstn(rstn), .sck(sck), .cs_n(cs_n), .io_in(io_in), .io_out(io_out),
    .io_oe(io_oe), .config_register_one(config_register_one), .four_byte_addr_enable(four_byte_addr_enable),
    .enhanced_latency_table(enhanced_latency_table), .mem_addr(mem_addr), .mem_rd_en(mem_rd_en),
    .mem_rd_data(mem_rd_data), .cont_mode(cont_mode));
  qdr_host_model u_host (.mclk(mclk), .sck(sck), .cs_n(cs_n), .io_in(io_in), .io_out(io_out), .io_oe(io_oe));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic run(input qdr_row_t r, input logic qe);
    config_register_one = {r.lat, 4'h0, qe, 1'h0};
    four_byte_addr_enable = r.ext;
    enhanced_latency_table = r.enh;
    u_host.frame(r.cmd, r.wc, r.addr, (r.cmd[0] && !r.ext) ? 24 : 32, r.cmd[7], r.enh && r.cmd[7], r.mode,
      dum_tab[r.lat]);
  endtask : run
  task automatic verify(input qdr_row_t r);
    logic [31:0] e;
    for (int i = 0; i < 3; i++) begin
      e = r.addr + i;
      check(u_host.got[i], {24'h0, e[7:0] + e[31:24] + 8'h11});
    end
    check(u_host.oe_seen, r.oe);
    check(cont_mode, r.cm);
    check(mem_rd_en, 1'h0);
  endtask : verify
  task automatic finish_test();
    $display("checked=%0d bad_count=%0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : finish_test
  initial begin
    mclk = 1'h0;
    forever #5 mclk = ~mclk;
  end
  initial begin
    #300000;
    bad_count++;
    finish_test();
  end
  initial begin
    rstn = 1'h0;
    config_register_one = 8'h00;
    four_byte_addr_enable = 1'h0;
    enhanced_latency_table = 1'h0;
    repeat (20) @(posedge mclk);
    #1;
    check(io_oe, 4'h0);
    check(mem_addr, 32'h0);
    check(mem_rd_en, 1'h0);
    rstn = 1'h1;
    repeat (3) @(posedge mclk);
    #1;
    foreach (rows[i]) begin
      run(rows[i], 1'h1);
      verify(rows[i]);
    end
    run(rows[5], 1'h1);
    check(cont_mode, 1'h1);
    u_host.burst(4);
    check(cont_mode, 1'h0);
    run(rows[0], 1'h0);
    check(u_host.oe_seen, 4'h0);
    finish_test();
  end
endmodule : tb_quad_dual_io_read_cmds
bind qdr_read_ctrl qdr_read_ctrl_sva u_sva (.mclk(mclk), .rstn(rstn), .sck(sck), .cs_n(cs_n), .io_in(io_in),
  .io_out(io_out), .io_oe(io_oe), .config_register_one(config_register_one),
  .four_byte_addr_enable(four_byte_addr_enable), .enhanced_latency_table(enhanced_latency_table),
  .mem_addr(mem_addr), .mem_rd_en(mem_rd_en), .mem_rd_data(mem_rd_data), .cont_mode(cont_mode));
